// File: smbus_port_defines.svh
`ifndef SMBUS_PORT_DEFINES_SVH
`define SMBUS_PORT_DEFINES_SVH

`define ADDR_UPPER_BITS 5'h0b
`define ADDR_DEFAULT_LOW 2'h2
`define ALERT_RESPONSE_ADDR 7'h0c
`define REG_GENERAL_CONFIGURATION_ONE 8'h40
`define CFG_TIMEOUT_DISABLE_BIT 6
`define CFG_RESET_VALUE 8'h00
`define CORE_CLK_MHZ 200
`define TIMEOUT_MIN_MS 15
`define TIMEOUT_CYCLES (`TIMEOUT_MIN_MS * `CORE_CLK_MHZ * 1000)
`define HOST_HALF_PERIOD 10'd100

`endif

// File: smbus_port_pkg.sv
package smbus_port_pkg;
  typedef enum logic [2:0] {
    SL_IDLE,
    SL_RX,
    SL_ACK,
    SL_TX,
    SL_TX_ACK,
    SL_IGNORE
  } slave_state_e;

  typedef enum logic [3:0] {
    HM_IDLE,
    HM_START,
    HM_BIT_LOW,
    HM_BIT_HIGH,
    HM_NEXT,
    HM_STOP_LOW,
    HM_STOP_HIGH,
    HM_STOP_DONE,
    HM_RSTART
  } host_state_e;

  typedef enum logic [1:0] {
    OP_SEND_BYTE,
    OP_WRITE_BYTE,
    OP_RECEIVE_BYTE,
    OP_ALERT_RESPONSE
  } host_op_e;
endpackage

// File: smbus_link_if.sv
`timescale 1ns/1ps
interface smbus_link_if;
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic alert_n_out;
  logic alert_n_oe;
  wire scl_line;
  wire sda_line;
  wire alert_n_line;

  // Open-drain wired-AND with pull-ups
  assign scl_line = !(scl_host_oe && !scl_host_out);
  assign sda_line = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
  assign alert_n_line = !(alert_n_oe && !alert_n_out);

  modport device (
    input scl_line,
    input sda_line,
    input alert_n_line,
    output sda_dev_out,
    output sda_dev_oe,
    output alert_n_out,
    output alert_n_oe
  );

  modport host (
    input scl_line,
    input sda_line,
    input alert_n_line,
    output scl_host_out,
    output scl_host_oe,
    output sda_host_out,
    output sda_host_oe
  );
endinterface

// File: smbus_slave_register_port.sv
`timescale 1ns/1ps
`include "smbus_port_defines.svh"
// Functional notes
// - Nine clocks per byte, MSB first, ack
// - Data stable on clock high; rising edge stops
// - Master ends writes with STOP
// - Master ends reads with NACK, STOP
// - Direction fixed until new START
// - Accept one/two byte writes, single reads
// - First written byte loads pointer
// - Second written byte stores to pointed register
// - Pointer persists between operations
// - Send Byte sets pointer
// - Repeated START after pointer write accepted
// - Write Byte stores data
// - Receive Byte returns pointed register
// - Answer alert response address while alerting
// - Arbitrate alert response, losers withdraw
// - Alert released only when condition clears
// - Timeout with clock high and data low releases data line
// - Config 0x40 bit 6 disables timeout
// - Address upper bits 01011 fixed
// - Straps choose low two address bits
// - Straps latched at first transaction
// - Ack own address, else stay idle
// - Alert low on any unmasked status
module smbus_slave_register_port
  import smbus_port_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
  parameter int REG_COUNT = 256
) (
  input wire logic core_clk,
  input wire logic rst_n,
  smbus_link_if.device link,
  input wire logic strap_address_enable,
  input wire logic strap_address_select,
  input wire logic [7:0] status_bits,
  input wire logic [7:0] status_mask,
  output logic [7:0] bus_timeout_disable_cfg,
  output logic [7:0] pointer_value,
  output logic write_strobe
);
  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    slave_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [1:0] byte_idx;
    logic [1:0] en_sync;
    logic [1:0] sel_sync;
    logic addr_latched;
    logic [6:0] own_addr;
    logic [7:0] pointer;
    logic sda_low;
    logic alert_low;
    logic [31:0] idle_cnt;
    logic wr_pulse;
  } dev_state_s;

  dev_state_s s_reg, s_next;
  logic [7:0] regs_reg [REG_COUNT];
  logic [7:0] regs_next [REG_COUNT];

  logic scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
  assign scl = s_reg.scl_sync[1];
  assign sda = s_reg.sda_sync[1];
  assign scl_rise = s_reg.scl_sync[1] && !s_reg.scl_sync[2];
  assign scl_fall = !s_reg.scl_sync[1] && s_reg.scl_sync[2];
  assign start_cond = scl && s_reg.scl_sync[2] && !sda && s_reg.sda_sync[2];
  assign stop_cond = scl && s_reg.scl_sync[2] && sda && !s_reg.sda_sync[2];

  function automatic logic [6:0] strap_addr(input logic en, input logic sel);
    strap_addr = en ? {`ADDR_UPPER_BITS, `ADDR_DEFAULT_LOW} : {`ADDR_UPPER_BITS, 1'b0, sel};
  endfunction

  always_comb begin
    logic [6:0] my_addr;
    logic tmo_en;
    s_next = s_reg;
    regs_next = regs_reg;
    my_addr = s_reg.own_addr;
    tmo_en = !regs_reg[`REG_GENERAL_CONFIGURATION_ONE][`CFG_TIMEOUT_DISABLE_BIT];
    s_next.scl_sync = {s_reg.scl_sync[1:0], link.scl_line};
    s_next.sda_sync = {s_reg.sda_sync[1:0], link.sda_line};
    // Straps are pins, so they cross two flops before the address is built
    s_next.en_sync = {s_reg.en_sync[0], strap_address_enable};
    s_next.sel_sync = {s_reg.sel_sync[0], strap_address_select};
    s_next.wr_pulse = 1'b0;
    s_next.alert_low = |(status_bits & ~status_mask);
    if (!scl || s_reg.state == SL_IDLE || !tmo_en) begin
      s_next.idle_cnt = 32'h0;
    end else if (scl && !sda && s_reg.idle_cnt < 32'(TIMEOUT_CYCLES)) begin
      s_next.idle_cnt = s_reg.idle_cnt + 32'h1;
    end
    if (scl_rise || scl_fall || (sda != s_reg.sda_sync[2])) begin
      s_next.idle_cnt = 32'h0;
    end
    if (tmo_en && s_reg.idle_cnt >= 32'(TIMEOUT_CYCLES)) begin
      s_next.state = SL_IDLE;
      s_next.sda_low = 1'b0;
      s_next.idle_cnt = 32'h0;
    end else if (stop_cond) begin
      s_next.state = SL_IDLE;
      s_next.sda_low = 1'b0;
    end else if (start_cond) begin
      // Repeated START also lands here, keeping the pointer
      s_next.state = SL_RX;
      s_next.bit_cnt = 4'h0;
      s_next.byte_idx = 2'h0;
      s_next.sda_low = 1'b0;
      if (!s_reg.addr_latched) begin
        s_next.addr_latched = 1'b1;
        s_next.own_addr = strap_addr(s_reg.en_sync[1], s_reg.sel_sync[1]);
      end
    end else begin
      if (!s_reg.addr_latched) begin
        my_addr = strap_addr(s_reg.en_sync[1], s_reg.sel_sync[1]);
      end
      case (s_reg.state)
        SL_IDLE: s_next.sda_low = 1'b0;
        SL_IGNORE: s_next.sda_low = 1'b0;
        SL_RX: begin
          if (scl_rise) begin
            s_next.shift = {s_reg.shift[6:0], sda};
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end else if (scl_fall && s_reg.bit_cnt == 4'h8) begin
            s_next.bit_cnt = 4'h0;
            if (s_reg.byte_idx == 2'h0) begin
              if (s_reg.shift[7:1] == my_addr || (s_reg.shift[7:1] == `ALERT_RESPONSE_ADDR
                  && s_reg.shift[0] && s_reg.alert_low)) begin
                s_next.state = SL_ACK;
                s_next.sda_low = 1'b1;
                s_next.tx = (s_reg.shift[7:1] == `ALERT_RESPONSE_ADDR) ? {my_addr, 1'b1}
                  : regs_reg[s_reg.pointer];
                s_next.shift[0] = s_reg.shift[0];
              end else begin
                s_next.state = SL_IGNORE;
              end
            end else if (s_reg.byte_idx == 2'h1) begin
              s_next.pointer = s_reg.shift;
              s_next.state = SL_ACK;
              s_next.sda_low = 1'b1;
            end else if (s_reg.byte_idx == 2'h2) begin
              regs_next[s_reg.pointer] = s_reg.shift;
              s_next.wr_pulse = 1'b1;
              s_next.state = SL_ACK;
              s_next.sda_low = 1'b1;
            end else begin
              s_next.state = SL_IGNORE;
            end
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            s_next.sda_low = 1'b0;
            if (s_reg.byte_idx == 2'h0 && s_reg.shift[0]) begin
              s_next.state = SL_TX;
              s_next.sda_low = !s_reg.tx[7];
              s_next.bit_cnt = 4'h0;
            end else begin
              s_next.state = SL_RX;
              s_next.byte_idx = s_reg.byte_idx + 2'h1;
            end
          end
        end
        SL_TX: begin
          if (scl_rise && s_reg.sda_low == 1'b0 && !sda) begin
            s_next.state = SL_IGNORE;
          end else if (scl_fall) begin
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            s_next.tx = {s_reg.tx[6:0], 1'b0};
            if (s_reg.bit_cnt == 4'h7) begin
              s_next.state = SL_TX_ACK;
              s_next.sda_low = 1'b0;
            end else begin
              s_next.sda_low = !s_reg.tx[6];
            end
          end
        end
        SL_TX_ACK: begin
          if (scl_fall) begin
            s_next.state = SL_IGNORE;
          end
        end
        default: s_next.state = SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{scl_sync: 3'h7, sda_sync: 3'h7, state: SL_IDLE, own_addr: 7'h0, default: '0};
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= `CFG_RESET_VALUE;
      end
    end else begin
      s_reg <= s_next;
      regs_reg <= regs_next;
    end
  end

  assign bus_timeout_disable_cfg = regs_reg[`REG_GENERAL_CONFIGURATION_ONE];
  assign pointer_value = s_reg.pointer;
  assign write_strobe = s_reg.wr_pulse;
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = s_reg.sda_low;
  assign link.alert_n_out = 1'b0;
  assign link.alert_n_oe = s_reg.alert_low;
endmodule

// File: smbus_host_master.sv
`timescale 1ns/1ps
`include "smbus_port_defines.svh"
module smbus_host_master
  import smbus_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  smbus_link_if.host link,
  input wire logic req_valid,
  input wire host_op_e req_op,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_cmd,
  input wire logic [7:0] req_data,
  input wire logic req_rstart_read,
  output logic busy,
  output logic done,
  output logic nacked,
  output logic [7:0] rd_data
);
  typedef struct packed {
    host_state_e state;
    logic [1:0] sda_sync;
    logic [9:0] tick;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [1:0] byte_total;
    logic reading;
    logic rstart;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic [7:0] data;
    logic [6:0] addr;
    logic scl_low;
    logic sda_low;
    logic busy;
    logic done;
    logic nacked;
    logic [7:0] rd;
  } host_state_s;

  host_state_s h_reg, h_next;
  logic sda;
  assign sda = h_reg.sda_sync[1];

  function automatic logic [7:0] byte_at(input host_state_s h, input logic [1:0] idx);
    byte_at = (idx == 2'h0) ? {h.addr, h.reading} : (idx == 2'h1) ? h.cmd : h.data;
  endfunction

  always_comb begin
    logic half;
    h_next = h_reg;
    h_next.sda_sync = {h_reg.sda_sync[0], link.sda_line};
    h_next.done = 1'b0;
    half = h_reg.tick == `HOST_HALF_PERIOD;
    h_next.tick = half ? 10'h0 : h_reg.tick + 10'h1;
    case (h_reg.state)
      HM_IDLE: begin
        h_next.tick = 10'h0;
        if (req_valid) begin
          h_next.busy = 1'b1;
          h_next.nacked = 1'b0;
          h_next.addr = req_op == OP_ALERT_RESPONSE ? `ALERT_RESPONSE_ADDR : req_addr;
          h_next.cmd = req_cmd;
          h_next.data = req_data;
          h_next.reading = req_op == OP_RECEIVE_BYTE || req_op == OP_ALERT_RESPONSE;
          h_next.byte_total = req_op == OP_WRITE_BYTE ? 2'h3 : (h_next.reading ? 2'h2 : 2'h2);
          h_next.rstart = req_op == OP_SEND_BYTE && req_rstart_read;
          h_next.state = HM_START;
          h_next.sda_low = 1'b1;
        end
      end
      HM_START: if (half) begin
        h_next.scl_low = 1'b1;
        h_next.byte_idx = 2'h0;
        h_next.bit_cnt = 4'h0;
        h_next.shift = byte_at(h_reg, 2'h0);
        h_next.state = HM_BIT_LOW;
      end
      HM_BIT_LOW: if (half) begin
        if (h_reg.bit_cnt < 4'h8) begin
          // Master drives data bits except during a read data byte after the address
          h_next.sda_low = (h_reg.reading && h_reg.byte_idx != 2'h0) ? 1'b0 : !h_reg.shift[7];
        end else begin
          h_next.sda_low = 1'b0;
        end
        h_next.state = HM_BIT_HIGH;
      end
      HM_BIT_HIGH: if (half) begin
        h_next.scl_low = 1'b0;
        h_next.state = HM_NEXT;
      end
      HM_NEXT: if (half) begin
        h_next.scl_low = 1'b1;
        if (h_reg.bit_cnt == 4'h8) begin
          if (!(h_reg.reading && h_reg.byte_idx != 2'h0) && sda) begin
            h_next.nacked = 1'b1;
            h_next.state = HM_STOP_LOW;
          end else if (h_reg.byte_idx + 2'h1 == h_reg.byte_total) begin
            h_next.state = h_reg.rstart ? HM_RSTART : HM_STOP_LOW;
          end else begin
            h_next.byte_idx = h_reg.byte_idx + 2'h1;
            h_next.bit_cnt = 4'h0;
            h_next.shift = byte_at(h_reg, h_reg.byte_idx + 2'h1);
            h_next.state = HM_BIT_LOW;
          end
        end else begin
          h_next.rd = {h_reg.rd[6:0], sda};
          h_next.shift = {h_reg.shift[6:0], 1'b0};
          h_next.bit_cnt = h_reg.bit_cnt + 4'h1;
          h_next.state = HM_BIT_LOW;
        end
      end
      HM_RSTART: if (half) begin
        h_next.sda_low = 1'b0;
        h_next.scl_low = 1'b0;
        h_next.rstart = 1'b0;
        h_next.reading = 1'b1;
        h_next.byte_total = 2'h2;
        h_next.state = HM_IDLE;
        h_next.busy = 1'b1;
        if (h_reg.sda_low == 1'b0 && h_reg.scl_low == 1'b0) begin
          h_next.sda_low = 1'b1;
          h_next.state = HM_START;
        end else begin
          h_next.state = HM_RSTART;
        end
      end
      HM_STOP_LOW: if (half) begin
        h_next.sda_low = 1'b1;
        h_next.state = HM_STOP_HIGH;
      end
      HM_STOP_HIGH: if (half) begin
        h_next.scl_low = 1'b0;
        h_next.state = HM_STOP_DONE;
      end
      HM_STOP_DONE: if (half) begin
        h_next.sda_low = 1'b0;
        h_next.busy = 1'b0;
        h_next.done = 1'b1;
        h_next.state = HM_IDLE;
      end
      default: h_next.state = HM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_reg <= '{state: HM_IDLE, sda_sync: 2'h3, default: '0};
    end else begin
      h_reg <= h_next;
    end
  end

  assign busy = h_reg.busy;
  assign done = h_reg.done;
  assign nacked = h_reg.nacked;
  assign rd_data = h_reg.rd;
  assign link.scl_host_out = 1'b0;
  assign link.scl_host_oe = h_reg.scl_low;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = h_reg.sda_low;
endmodule

// File: smbus_slave_register_port_chk.sv
`timescale 1ns/1ps
`include "smbus_port_defines.svh"
module smbus_slave_register_port_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic alert_n_line,
  input wire logic sda_dev_oe,
  input wire logic [7:0] status_bits,
  input wire logic [7:0] status_mask,
  input wire logic strap_address_enable,
  input wire logic strap_address_select
);
  logic scl_d, sda_d, idle, own_set;
  logic [6:0] own;
  logic [3:0] cnt;
  logic [1:0] bi;
  logic [7:0] sh, hdr;
  wire logic sta = scl_line && scl_d && sda_d && !sda_line;
  wire logic sto = scl_line && scl_d && !sda_d && sda_line;
  wire logic rise = scl_line && !scl_d;
  wire logic slot = rise && cnt == 4'd8;
  wire logic pend = |(status_bits & ~status_mask);
  wire logic hit = (sh[7:1] == own) || (sh == {`ALERT_RESPONSE_ADDR, 1'b1} && !alert_n_line);
  wire logic [7:0] ara = {own, 1'b1};

  // Frame tracker: bit count restarts on every START, so repeated START is handled too
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      idle <= 1'b1;
      cnt <= 4'h0;
      bi <= 2'h0;
      sh <= 8'h00;
      hdr <= 8'h00;
      own <= 7'h00;
      own_set <= 1'b0;
    end else begin
      scl_d <= scl_line;
      sda_d <= sda_line;
      if (sta) begin
        cnt <= 4'h0;
        bi <= 2'h0;
        idle <= 1'b0;
        // Address is fixed by the straps seen at the first START after reset
        if (!own_set) begin
          own_set <= 1'b1;
          own <= strap_address_enable ? {`ADDR_UPPER_BITS, `ADDR_DEFAULT_LOW}
            : {`ADDR_UPPER_BITS, 1'b0, strap_address_select};
        end
      end else if (sto) begin
        idle <= 1'b1;
      end else if (rise) begin
        sh <= {sh[6:0], sda_line};
        if (cnt == 4'd8) begin
          cnt <= 4'h0;
          bi <= bi + 2'h1;
          if (bi == 2'h0) begin
            hdr <= sh;
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_ADDR_ACK: assert property (slot && bi == 2'd0 |-> sda_line == !hit)
    else $error("address ack wrong");
  AST_DATA_ACK: assert property (slot && (bi == 2'd1 || bi == 2'd2) && hdr == {own, 1'b0} |-> !sda_line)
    else $error("write byte not acked");
  AST_READ_ACK_FREE: assert property (slot && bi != 2'd0 && hdr[0] |-> !sda_dev_oe)
    else $error("device drove master ack slot");
  AST_ARA_DATA: assert property (rise && bi == 2'd1 && cnt != 4'd8 && hdr == {`ALERT_RESPONSE_ADDR, 1'b1}
    |-> sda_line == ara[3'd7 - cnt[2:0]])
    else $error("alert response bit wrong");
  AST_ADDR_QUIET: assert property (!idle && bi == 2'd0 && cnt != 4'd8 |-> !sda_dev_oe)
    else $error("device drove during address");
  AST_IDLE_RELEASED: assert property (idle |-> !sda_dev_oe)
    else $error("data line held while idle");
  AST_SDA_STABLE_HIGH: assert property (scl_line && scl_d |-> $stable(sda_dev_oe))
    else $error("data changed with clock high");
  AST_ALERT_ON: assert property (pend |-> ##[0:3] !alert_n_line)
    else $error("alert not driven");
  AST_ALERT_OFF: assert property (!pend [*4] |-> alert_n_line)
    else $error("alert held without cause");

  cover property (slot && bi == 2'd0 && !sda_line);
  cover property (rise && bi == 2'd1 && hdr == {`ALERT_RESPONSE_ADDR, 1'b1});
  cover property (slot && bi == 2'd2);
endmodule

// File: tb_smbus_slave_register_port.sv
`timescale 1ns/1ps
`include "smbus_port_defines.svh"
module tb_smbus_slave_register_port;
  import smbus_port_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap_address_enable = 1'b0;
  logic strap_address_select = 1'b1;
  logic [7:0] status_bits = 8'h00;
  logic [7:0] status_mask = 8'h00;
  logic req_valid = 1'b0;
  host_op_e req_op = OP_SEND_BYTE;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_cmd = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic req_rstart_read = 1'b0;
  logic [7:0] bus_timeout_disable_cfg, pointer_value, rd_data;
  logic write_strobe, busy, done, nacked;
  logic strobe_seen = 1'b0;
  int bad_count = 0;
  int n_tests = 0;

  always #2.5 core_clk = ~core_clk;

  smbus_link_if smbus_link_if_inst ();

  // Short timeout keeps a stuck bus visible within the run
  smbus_slave_register_port #(.TIMEOUT_CYCLES(2000)) smbus_slave_register_port_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link(smbus_link_if_inst.device),
    .strap_address_enable(strap_address_enable),
    .strap_address_select(strap_address_select),
    .status_bits(status_bits),
    .status_mask(status_mask),
    .bus_timeout_disable_cfg(bus_timeout_disable_cfg),
    .pointer_value(pointer_value),
    .write_strobe(write_strobe)
  );

  smbus_host_master smbus_host_master_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link(smbus_link_if_inst.host),
    .req_valid(req_valid),
    .req_op(req_op),
    .req_addr(req_addr),
    .req_cmd(req_cmd),
    .req_data(req_data),
    .req_rstart_read(req_rstart_read),
    .busy(busy),
    .done(done),
    .nacked(nacked),
    .rd_data(rd_data)
  );

  smbus_slave_register_port_chk smbus_slave_register_port_chk_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_line(smbus_link_if_inst.scl_line),
    .sda_line(smbus_link_if_inst.sda_line),
    .alert_n_line(smbus_link_if_inst.alert_n_line),
    .sda_dev_oe(smbus_link_if_inst.sda_dev_oe),
    .status_bits(status_bits),
    .status_mask(status_mask),
    .strap_address_enable(strap_address_enable),
    .strap_address_select(strap_address_select)
  );

  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Sampling 1 ns after the edge lets the design's updates land first
  task automatic run_op(input host_op_e op, input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                        input logic rs);
    int i;
    @(posedge core_clk);
    req_op <= op;
    req_addr <= a;
    req_cmd <= c;
    req_data <= d;
    req_rstart_read <= rs;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    strobe_seen = 1'b0;
    for (i = 0; i < 40000 && done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
      if (write_strobe === 1'b1) begin
        strobe_seen = 1'b1;
      end
    end
    if (done !== 1'b1) begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic t_write_byte();
    run_op(OP_WRITE_BYTE, 7'h2d, 8'h10, 8'ha5, 1'b0);
    chk8("write nacked", 8'h00, {7'h00, nacked});
    chk8("pointer", 8'h10, pointer_value);
    chk8("write strobe", 8'h01, {7'h00, strobe_seen});
    chk8("busy after stop", 8'h00, {7'h00, busy});
  endtask

  task automatic t_receive();
    run_op(OP_RECEIVE_BYTE, 7'h2d, 8'h00, 8'h00, 1'b0);
    chk8("receive nacked", 8'h00, {7'h00, nacked});
    chk8("receive data", 8'ha5, rd_data);
  endtask

  task automatic t_send_rstart();
    chk8("cfg reset", `CFG_RESET_VALUE, bus_timeout_disable_cfg);
    run_op(OP_SEND_BYTE, 7'h2d, `REG_GENERAL_CONFIGURATION_ONE, 8'h00, 1'b1);
    chk8("pointer", `REG_GENERAL_CONFIGURATION_ONE, pointer_value);
    chk8("rstart data", `CFG_RESET_VALUE, rd_data);
  endtask

  task automatic t_write_cfg();
    run_op(OP_WRITE_BYTE, 7'h2d, `REG_GENERAL_CONFIGURATION_ONE, 8'h40, 1'b0);
    chk8("cfg", 8'h40, bus_timeout_disable_cfg);
  endtask

  task automatic t_foreign_and_strap();
    run_op(OP_SEND_BYTE, 7'h2c, 8'h77, 8'h00, 1'b0);
    chk8("foreign nacked", 8'h01, {7'h00, nacked});
    chk8("pointer kept", `REG_GENERAL_CONFIGURATION_ONE, pointer_value);
    strap_address_select <= 1'b0;
    run_op(OP_RECEIVE_BYTE, 7'h2d, 8'h00, 8'h00, 1'b0);
    chk8("latched addr nacked", 8'h00, {7'h00, nacked});
    chk8("latched addr data", 8'h40, rd_data);
  endtask

  task automatic t_alert();
    status_bits <= 8'h01;
    run_op(OP_ALERT_RESPONSE, `ALERT_RESPONSE_ADDR, 8'h00, 8'h00, 1'b0);
    chk8("ara nacked", 8'h00, {7'h00, nacked});
    chk8("ara data", {7'h2d, 1'b1}, rd_data);
    chk8("alert held", 8'h00, {7'h00, smbus_link_if_inst.alert_n_line});
    status_mask <= 8'h01;
    run_op(OP_ALERT_RESPONSE, `ALERT_RESPONSE_ADDR, 8'h00, 8'h00, 1'b0);
    chk8("masked ara nacked", 8'h01, {7'h00, nacked});
    chk8("alert masked", 8'h01, {7'h00, smbus_link_if_inst.alert_n_line});
  endtask

  // A second reset must relatch the straps, now with the enable strap high
  task automatic t_reset_strap();
    @(posedge core_clk);
    rst_n <= 1'b0;
    strap_address_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk8("reset cfg", `CFG_RESET_VALUE, bus_timeout_disable_cfg);
    chk8("reset pointer", 8'h00, pointer_value);
    chk8("reset alert", 8'h01, {7'h00, smbus_link_if_inst.alert_n_line});
    run_op(OP_WRITE_BYTE, 7'h2e, 8'h05, 8'h3c, 1'b0);
    chk8("enable strap nacked", 8'h00, {7'h00, nacked});
    run_op(OP_RECEIVE_BYTE, 7'h2e, 8'h00, 8'h00, 1'b0);
    chk8("enable strap data", 8'h3c, rd_data);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_write_byte();
    t_receive();
    t_send_rstart();
    t_write_cfg();
    t_foreign_and_strap();
    t_alert();
    t_reset_strap();
    complete_run();
  end
endmodule
